// File: sba_arbiter.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// RQ1: Up period end reloads down-to-up count, bits 7:0
// RQ2: Up period end reloads peer count, bits 15:8
// RQ3: Up period end reloads up-to-self count, bits 23:16
// RQ4: Up period end reloads down-to-self count, bits 31:24
// RQ5: Down period end reloads up-to-down count, bits 7:0
// RQ6: Down period end reloads decoupler count, bits 15:8
// RQ7: Weights: 8-bit RW, reset 0x01, sticky
// RQ8: Remaining counts read-only, reset 0x01
// RQ9: Grant decrements; zero blocks; idle starts period
// RQ10: Writes to RO/reserved ignored; reserved read zero
module sba_arbiter
  import sba_pkg::*;
(
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic                      rst_fundamental,
  input  wire sba_apb_req_t              apb_req,
  output var  sba_apb_rsp_t              apb_rsp,
  input  wire logic [SBA_UP_CLASSES-1:0] up_req,
  output logic      [SBA_UP_CLASSES-1:0] up_grant,
  input  wire logic [SBA_DN_CLASSES-1:0] dn_req,
  output logic      [SBA_DN_CLASSES-1:0] dn_grant
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode
  logic                  access_phase;
  logic                  wr_stb;
  logic                  hit_up_prog;
  logic                  hit_up_cur;
  logic                  hit_dn_prog;
  logic                  hit_dn_cur;
  logic                  hit_any;
  logic [SBA_DATA_W-1:0] rdata_next;

  assign access_phase = apb_req.psel & apb_req.penable;
  assign wr_stb       = access_phase & apb_req.pwrite;
  assign hit_up_prog  = apb_req.paddr == SBA_UP_PROG_OFS;
  assign hit_up_cur   = apb_req.paddr == SBA_UP_CUR_OFS;
  assign hit_dn_prog  = apb_req.paddr == SBA_DN_PROG_OFS;
  assign hit_dn_cur   = apb_req.paddr == SBA_DN_CUR_OFS;
  assign hit_any      = hit_up_prog | hit_up_cur | hit_dn_prog | hit_dn_cur;

  ////////////////////////////////////////////////////////////////////////////
  // Weights and remaining counts
  logic [SBA_UP_CLASSES*SBA_CNT_W-1:0] up_weight_reg;
  logic [SBA_DN_CLASSES*SBA_CNT_W-1:0] dn_weight_reg;
  logic [SBA_UP_CLASSES*SBA_CNT_W-1:0] up_remaining_reg;
  logic [SBA_DN_CLASSES*SBA_CNT_W-1:0] dn_remaining_reg;
  logic [SBA_UP_CLASSES*SBA_CNT_W-1:0] up_remaining_next;
  logic [SBA_DN_CLASSES*SBA_CNT_W-1:0] dn_remaining_next;

  // Named field views
  logic [SBA_CNT_W-1:0] down_to_up_weight;
  logic [SBA_CNT_W-1:0] peer_weight;
  logic [SBA_CNT_W-1:0] up_to_self_weight;
  logic [SBA_CNT_W-1:0] down_to_self_weight;
  logic [SBA_CNT_W-1:0] up_to_down_weight;
  logic [SBA_CNT_W-1:0] decoupler_queue_weight;
  logic [SBA_CNT_W-1:0] down_to_up_remaining;
  logic [SBA_CNT_W-1:0] peer_remaining;
  logic [SBA_CNT_W-1:0] up_to_self_remaining;
  logic [SBA_CNT_W-1:0] down_to_self_remaining;
  logic [SBA_CNT_W-1:0] up_to_down_remaining;
  logic [SBA_CNT_W-1:0] decoupler_queue_remaining;

  assign down_to_up_weight         = up_weight_reg[SBA_UP_D2U*SBA_CNT_W +: SBA_CNT_W];
  assign peer_weight               = up_weight_reg[SBA_UP_P2P*SBA_CNT_W +: SBA_CNT_W];
  assign up_to_self_weight         = up_weight_reg[SBA_UP_U2S*SBA_CNT_W +: SBA_CNT_W];
  assign down_to_self_weight       = up_weight_reg[SBA_UP_D2S*SBA_CNT_W +: SBA_CNT_W];
  assign up_to_down_weight         = dn_weight_reg[SBA_DN_U2D*SBA_CNT_W +: SBA_CNT_W];
  assign decoupler_queue_weight    = dn_weight_reg[SBA_DN_BDQ*SBA_CNT_W +: SBA_CNT_W];
  assign down_to_up_remaining      = up_remaining_reg[SBA_UP_D2U*SBA_CNT_W +: SBA_CNT_W];
  assign peer_remaining            = up_remaining_reg[SBA_UP_P2P*SBA_CNT_W +: SBA_CNT_W];
  assign up_to_self_remaining      = up_remaining_reg[SBA_UP_U2S*SBA_CNT_W +: SBA_CNT_W];
  assign down_to_self_remaining    = up_remaining_reg[SBA_UP_D2S*SBA_CNT_W +: SBA_CNT_W];
  assign up_to_down_remaining      = dn_remaining_reg[SBA_DN_U2D*SBA_CNT_W +: SBA_CNT_W];
  assign decoupler_queue_remaining = dn_remaining_reg[SBA_DN_BDQ*SBA_CNT_W +: SBA_CNT_W];

  // Sticky: only the fundamental reset restores the weights
  always_ff @(posedge mclk)
  begin
    if (rst_fundamental)
    begin
      up_weight_reg <= {SBA_UP_CLASSES{SBA_CNT_RESET}}; // RQ7
      dn_weight_reg <= {SBA_DN_CLASSES{SBA_CNT_RESET}}; // RQ7
    end
    else
    begin
      if (wr_stb && hit_up_prog)
        up_weight_reg <= apb_req.pwdata; // RQ7
      if (wr_stb && hit_dn_prog)
        dn_weight_reg <= apb_req.pwdata[SBA_DN_CLASSES*SBA_CNT_W-1:0]; // RQ10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Both buses: fixed priority among eligible classes
  logic [SBA_UP_CLASSES-1:0] up_eligible;
  logic                      up_period_end;
  logic [SBA_DN_CLASSES-1:0] dn_eligible;
  logic                      dn_period_end;

  always_comb
  begin
    for (int i = 0; i < SBA_UP_CLASSES; i++)
      up_eligible[i] = up_req[i] &&
        (up_remaining_reg[i*SBA_CNT_W +: SBA_CNT_W] != SBA_CNT_ZERO); // RQ9
    for (int j = 0; j < SBA_DN_CLASSES; j++)
      dn_eligible[j] = dn_req[j] &&
        (dn_remaining_reg[j*SBA_CNT_W +: SBA_CNT_W] != SBA_CNT_ZERO); // RQ9
  end

  // A period ends when nobody with credit is asking
  assign up_period_end = ~|up_eligible; // RQ9
  assign dn_period_end = ~|dn_eligible; // RQ9

  // Lowest index wins; credits bound how long one class can hold the bus
  assign up_grant = up_eligible & (~up_eligible + SBA_UP_CLASSES'(1)); // RQ9
  assign dn_grant = dn_eligible & (~dn_eligible + SBA_DN_CLASSES'(1)); // RQ9

  always_comb
  begin
    up_remaining_next = up_remaining_reg;
    dn_remaining_next = dn_remaining_reg;
    if (up_period_end)
      up_remaining_next = up_weight_reg; // RQ1 RQ2 RQ3 RQ4
    else
      for (int i = 0; i < SBA_UP_CLASSES; i++)
        if (up_grant[i])
          up_remaining_next[i*SBA_CNT_W +: SBA_CNT_W] =
            up_remaining_reg[i*SBA_CNT_W +: SBA_CNT_W] - SBA_CNT_ONE; // RQ9
    if (dn_period_end)
      dn_remaining_next = dn_weight_reg; // RQ5 RQ6
    else
      for (int j = 0; j < SBA_DN_CLASSES; j++)
        if (dn_grant[j])
          dn_remaining_next[j*SBA_CNT_W +: SBA_CNT_W] =
            dn_remaining_reg[j*SBA_CNT_W +: SBA_CNT_W] - SBA_CNT_ONE; // RQ9
  end

  always_ff @(posedge mclk)
  begin
    if (rst || rst_fundamental)
    begin
      up_remaining_reg <= {SBA_UP_CLASSES{SBA_CNT_RESET}}; // RQ8
      dn_remaining_reg <= {SBA_DN_CLASSES{SBA_CNT_RESET}}; // RQ8
    end
    else
    begin
      up_remaining_reg <= up_remaining_next;
      dn_remaining_reg <= dn_remaining_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; remaining-count and reserved bits ignore writes
  assign rdata_next =
      hit_up_prog ? up_weight_reg :
      hit_up_cur  ? up_remaining_reg :                                  // RQ8
      hit_dn_prog ? {{(SBA_DATA_W-SBA_DN_CLASSES*SBA_CNT_W){1'b0}}, dn_weight_reg} :
      hit_dn_cur  ? {{(SBA_DATA_W-SBA_DN_CLASSES*SBA_CNT_W){1'b0}}, dn_remaining_reg} :
      SBA_RD_ZERO; // RQ10

  // Zero wait states: pready is high throughout every access phase
  always_comb
  begin
    apb_rsp.pready  = access_phase;
    apb_rsp.prdata  = (access_phase && !apb_req.pwrite) ? rdata_next : SBA_RD_ZERO;
    apb_rsp.pslverr = access_phase && !hit_any;
  end

endmodule : sba_arbiter

`default_nettype wire

// File: sba_pkg.sv
package sba_pkg;

  localparam int unsigned SBA_ADDR_W     = 12;
  localparam int unsigned SBA_DATA_W     = 32;
  localparam int unsigned SBA_CNT_W      = 8;
  localparam int unsigned SBA_UP_CLASSES = 4;
  localparam int unsigned SBA_DN_CLASSES = 2;

  // Register byte addresses
  localparam logic [SBA_ADDR_W-1:0] SBA_UP_PROG_OFS = 12'h458;
  localparam logic [SBA_ADDR_W-1:0] SBA_UP_CUR_OFS  = 12'h45c;
  localparam logic [SBA_ADDR_W-1:0] SBA_DN_PROG_OFS = 12'h460;
  localparam logic [SBA_ADDR_W-1:0] SBA_DN_CUR_OFS  = 12'h464;

  // Field reset value, shared by programmed and current counts
  localparam logic [SBA_CNT_W-1:0] SBA_CNT_RESET = 8'h01;
  localparam logic [SBA_CNT_W-1:0] SBA_CNT_ZERO  = 8'h00;
  localparam logic [SBA_CNT_W-1:0] SBA_CNT_ONE   = 8'h01;
  localparam logic [SBA_DATA_W-1:0] SBA_RD_ZERO  = 32'h0000_0000;

  // Upstream-bound bus class slots: field k sits at bits 8k+7:8k
  localparam int unsigned SBA_UP_D2U  = 0;
  localparam int unsigned SBA_UP_P2P  = 1;
  localparam int unsigned SBA_UP_U2S  = 2;
  localparam int unsigned SBA_UP_D2S  = 3;
  // Downstream-bound bus class slots
  localparam int unsigned SBA_DN_U2D  = 0;
  localparam int unsigned SBA_DN_BDQ  = 1;

  typedef struct packed {
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [SBA_ADDR_W-1:0] paddr;
    logic [SBA_DATA_W-1:0] pwdata;
  } sba_apb_req_t;

  typedef struct packed {
    logic                  pready;
    logic [SBA_DATA_W-1:0] prdata;
    logic                  pslverr;
  } sba_apb_rsp_t;

endpackage : sba_pkg

// File: sba_arbiter_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sba_checker
  import sba_pkg::*;
(
  input wire logic                      mclk,
  input wire logic                      rst,
  input wire logic                      rst_fundamental,
  input wire sba_apb_req_t              apb_req,
  input wire sba_apb_rsp_t              apb_rsp,
  input wire logic [SBA_UP_CLASSES-1:0] up_req,
  input wire logic [SBA_UP_CLASSES-1:0] up_grant,
  input wire logic [SBA_DN_CLASSES-1:0] dn_req,
  input wire logic [SBA_DN_CLASSES-1:0] dn_grant
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst || rst_fundamental);
  wire logic        rd = apb_req.psel && apb_req.penable && !apb_req.pwrite;
  wire logic        wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  wire logic [11:0] a  = apb_req.paddr;
  wire logic        blk_u = rst || rst_fundamental || (wr && a == SBA_UP_PROG_OFS);
  wire logic        blk_d = rst || rst_fundamental || (wr && a == SBA_DN_PROG_OFS);
  logic      [31:0] uw_reg;
  logic      [15:0] dw_reg;
  // Shadow weights survive ordinary reset, as the real ones must
  always_ff @(posedge mclk)
    if (rst_fundamental) uw_reg <= 32'h0101_0101;
    else if (wr && a == SBA_UP_PROG_OFS) uw_reg <= apb_req.pwdata;
  always_ff @(posedge mclk)
    if (rst_fundamental) dw_reg <= 16'h0101;
    else if (wr && a == SBA_DN_PROG_OFS) dw_reg <= apb_req.pwdata[15:0];
  ////////////////////////////////////////////////////////////////////////////
  up_grant_a: assert property ($onehot0(up_grant) && (up_grant & ~up_req) == 4'h0)
    else $error("up grant not one-hot or not requested");
  dn_grant_a: assert property ($onehot0(dn_grant) && (dn_grant & ~dn_req) == 2'h0)
    else $error("down grant not one-hot or not requested");
  up_weight_a: assert property (rd && a == SBA_UP_PROG_OFS |-> apb_rsp.prdata == uw_reg)
    else $error("up weights read back wrong");
  dn_weight_a: assert property (rd && a == SBA_DN_PROG_OFS |-> apb_rsp.prdata == dw_reg)
    else $error("down weights read back wrong");
  up_reload_a: assert property (rd && a == SBA_UP_CUR_OFS && $past(up_grant) == 4'h0
    && !$past(blk_u) |-> apb_rsp.prdata == uw_reg) else $error("up counts not reloaded");
  dn_reload_a: assert property (rd && a == SBA_DN_CUR_OFS && $past(dn_grant) == 2'h0
    && !$past(blk_d) |-> apb_rsp.prdata == dw_reg) else $error("down counts not reloaded");
  resv_zero_a: assert property (rd && a[3] == 1'b0 |-> apb_rsp.prdata[31:16] == 16'h0000)
    else $error("reserved bits not zero");
  unmapped_a: assert property (rd && !(a inside {[12'h458:12'h467]})
    |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000) else $error("unmapped read wrong");
  cover property (rd && a == SBA_UP_CUR_OFS && $past(up_grant) == 4'h0 && !$past(blk_u));
  cover property (rd && a == SBA_DN_CUR_OFS && $past(dn_grant) == 2'h0 && !$past(blk_d));
  cover property (up_grant[3] && dn_grant[1]);
endmodule : sba_checker
bind sba_arbiter sba_checker u_chk (.mclk(mclk), .rst(rst), .rst_fundamental(rst_fundamental),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .up_req(up_req), .up_grant(up_grant),
  .dn_req(dn_req), .dn_grant(dn_grant));
`default_nettype wire

// File: sba_req_model.sv
`timescale 1ns/1ps
`default_nettype none
module sba_req_model
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [5:0] rnd,
  input  wire logic [3:0] up_grant,
  input  wire logic [1:0] dn_grant,
  output logic      [3:0] up_req,
  output logic      [1:0] dn_req
);
  // A queue holds its request until served; a blocked class waits for the next period
  always_ff @(posedge mclk)
    if (rst) {dn_req, up_req} <= 6'h00;
    else {dn_req, up_req} <= ({dn_req, up_req} & ~{dn_grant, up_grant}) | rnd;
endmodule : sba_req_model
`default_nettype wire

// File: switch_bus_arbiter_weights_tb.sv
`timescale 1ns/1ps
`default_nettype none
module switch_bus_arbiter_weights_tb;
  import sba_pkg::*;
  logic         mclk = 1'b0;
  logic         rst = 1'b1;
  logic         rstf = 1'b1;
  sba_apb_req_t apb_req = '0;
  sba_apb_rsp_t apb_rsp;
  logic [5:0]   rnd = 6'h00;
  logic [3:0]   up_req, up_grant;
  logic [1:0]   dn_req, dn_grant;
  logic [31:0]  lf = 32'h6cb0;
  logic [31:0]  exp_rd = 32'h0000_0000;
  logic [7:0]   w[6], r[6];
  logic [11:0]  adr[5] = '{12'h458, 12'h45c, 12'h460, 12'h464, 12'h468};
  int           fail_count = 0;
  int           n_compared = 0;
  always #5 mclk = ~mclk;
  sba_arbiter dut (.mclk(mclk), .rst(rst), .rst_fundamental(rstf), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .up_req(up_req), .up_grant(up_grant), .dn_req(dn_req), .dn_grant(dn_grant));
  sba_req_model peer (.mclk(mclk), .rst(rst), .rnd(rnd), .up_grant(up_grant),
    .dn_grant(dn_grant), .up_req(up_req), .dn_req(dn_req));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (e !== g)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    logic bad;
    bad = !(a inside {12'h458, 12'h45c, 12'h460, 12'h464});
    @(posedge mclk);
    apb_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    do @(posedge mclk); while (apb_rsp.pready !== 1'b1);
    // Answer taken at the very edge that completes the transfer
    check("pslverr", 32'(bad), 32'(apb_rsp.pslverr));
    if (!wr)
      check("prdata", exp_rd, apb_rsp.prdata);
    apb_req <= '0;
  endtask : apb
  task automatic finish_test();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////////
  // Sparse requests so that idle cycles, and thus period ends, occur
  always @(posedge mclk)
  begin
    lf <= lfsr(lf);
    rnd <= lf[5:0] & lf[13:8];
  end
  // Reference model: sampled mid-cycle, updated as the next edge will
  always @(negedge mclk)
  begin : model
    logic [5:0]  el, g, rq;
    rq = {dn_req, up_req};
    g = 6'h00;
    for (int i = 0; i < 6; i++)
      el[i] = rq[i] && r[i] != 8'h00;
    // Scanned from the top down, so the lowest eligible class wins
    for (int i = 3; i >= 0; i--)
      if (el[i]) g[3:0] = 4'h1 << i;
    for (int i = 5; i >= 4; i--)
      if (el[i]) g[5:4] = 2'h1 << (i - 4);
    case (apb_req.paddr)
      12'h458: exp_rd = {w[3], w[2], w[1], w[0]};
      12'h45c: exp_rd = {r[3], r[2], r[1], r[0]};
      12'h460: exp_rd = {16'h0000, w[5], w[4]};
      12'h464: exp_rd = {16'h0000, r[5], r[4]};
      default: exp_rd = 32'h0000_0000;
    endcase
    if (!rst && !rstf)
    begin
      check("up_grant", 32'(g[3:0]), 32'(up_grant));
      check("dn_grant", 32'(g[5:4]), 32'(dn_grant));
    end
    for (int i = 0; i < 6; i++)
    begin
      if (rst || rstf) r[i] = 8'h01;
      else if (i < 4 ? g[3:0] == 4'h0 : g[5:4] == 2'h0) r[i] = w[i];
      else if (g[i]) r[i] = r[i] - 8'h01;
      if (rstf) w[i] = 8'h01;
      else if (apb_req.psel && apb_req.penable && apb_req.pwrite
               && apb_req.paddr == (i < 4 ? 12'h458 : 12'h460))
        w[i] = apb_req.pwdata[8*(i%4) +: 8];
    end
  end
  initial
  begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    rstf <= 1'b0;
    for (int t = 0; t < 6; t++)
    begin
      foreach (adr[k]) apb(1'b0, adr[k], 32'h0);
      foreach (adr[k]) apb(1'b1, adr[k], lf & 32'hff07_0307);
      repeat (20) foreach (adr[k]) apb(1'b0, adr[k], 32'h0);
      // Ordinary reset keeps weights; fundamental one resets them to 0x01
      rst <= (t == 2);
      rstf <= (t == 4);
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      rstf <= 1'b0;
      $display("Round %0d done", t);
    end
    finish_test();
  end
  initial
  begin
    #100000;
    fail_count++;
    finish_test();
  end
endmodule : switch_bus_arbiter_weights_tb
`default_nettype wire
